// File: src/pfcs_host.sv
// pfcs_host: host controller driving a byte-wide parallel flash
`timescale 1ns/1ns
// What this block and the flash it drives do
// (R1) read: select low, output enable low, strobe high
// (R2) address and data held across whole strobe
// (R3) select held high while idle, no access
// (R4) never drive data while output enable low
// (R5) id voltage raised only for hardware id reads
// (R6) software id entry is three writes
// (R7) program is four write cycles
// (R8) fourth program write carries address and data
// (R9) device self-times; host only polls status
// (R10) program clears bits only; erase restores ones
// (R11) chip erase is six writes, starts immediately
// (R12) no command issued while erase runs
// (R13) after erase completes host returns idle
// (R14) sector erase address cleared below 4 kbyte
// (R15) block erase address cleared below 64 kbyte
// (R16) small part: block erase becomes chip erase
// (R17) program polling: bit 7 inverted until done
// (R18) erase polling: bit 7 zero until done
// (R19) done when bit 6 stops toggling
// (R20) toggle read at any address
// (R21) write: select, strobe low, output enable high
// (R22) strobe low far longer than noise filter
// (R23) every command opens with unlock pair; the short id exit is one F0h write with no unlock
// (R24) erase: unlock, 80h, unlock, final code
// (R25) id entry 90h; exit F0h, short or long
// (R26) id codes at low addresses zero and one
// (R27) aborted sequence returns device to read
module pfcs_host (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        small_density,
  input  wire logic                        cmd_valid,
  output      logic                        cmd_ready,
  input  wire pfcs_pkg::pfcs_cmd_type      cmd,
  output      logic                        rsp_valid,
  output      logic [pfcs_pkg::DATA_W-1:0] rsp_data,
  output      pfcs_pkg::pfcs_pins_type     pins,
  output      logic                        id_voltage_pin,
  output      logic [pfcs_pkg::DATA_W-1:0] data_bus_o,
  output      logic                        data_bus_oe,
  input  wire logic [pfcs_pkg::DATA_W-1:0] data_bus_i
);

  // ----------------------------------------------------------------------
  // reset release and input synchroniser
  // ----------------------------------------------------------------------
  logic [1:0]                  rst_sync_q;   // reset release chain
  logic                        rst_n_sync;   // released reset
  logic [pfcs_pkg::DATA_W-1:0] din_meta_q;   // first sync stage
  logic [pfcs_pkg::DATA_W-1:0] din_sync_q;   // second sync stage

  // release reset through two flops, assert at once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n_sync = rst_sync_q[1];

  // data pins come from another chip, so they are synchronised first
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      din_meta_q <= 8'h00;
      din_sync_q <= 8'h00;
    end else begin
      din_meta_q <= data_bus_i;
      din_sync_q <= din_meta_q;
    end
  end

  // ----------------------------------------------------------------------
  // command sequence table
  // ----------------------------------------------------------------------
  // bus cycle number idx of a command; unlock pair shared by all but the short id exit
  function automatic pfcs_pkg::pfcs_step_type seq_step(
    input pfcs_pkg::pfcs_cmd_type c,
    input logic [2:0]             idx
  );
    pfcs_pkg::pfcs_step_type s;
    s.addr = pfcs_pkg::ADDR_UNLOCK1;
    s.data = pfcs_pkg::DAT_UNLOCK1;
    if (c.op == pfcs_pkg::OP_ID_RESET) begin
      s.addr = c.addr;                          // short exit, any address
      s.data = pfcs_pkg::DAT_ID_EXIT;           // R25
    end else begin
      case (idx)
        3'h1, 3'h4: begin
          s.addr = pfcs_pkg::ADDR_UNLOCK2;      // R23
          s.data = pfcs_pkg::DAT_UNLOCK2;
        end
        3'h2: begin
          case (c.op)
            pfcs_pkg::OP_PROGRAM:  s.data = pfcs_pkg::DAT_PROGRAM;  // R23
            pfcs_pkg::OP_ID_ENTRY: s.data = pfcs_pkg::DAT_ID_ENTRY; // R25
            pfcs_pkg::OP_ID_EXIT:  s.data = pfcs_pkg::DAT_ID_EXIT;  // R25
            default:               s.data = pfcs_pkg::DAT_ERASE;    // R24
          endcase
        end
        3'h3: begin
          if (c.op == pfcs_pkg::OP_PROGRAM) begin
            s.addr = c.addr;                    // R8
            s.data = c.data;                    // R8
          end
        end
        3'h5: begin
          case (c.op)
            pfcs_pkg::OP_SECTOR_ERASE: begin
              s.addr = c.addr & pfcs_pkg::SECTOR_MASK;   // R14
              s.data = pfcs_pkg::DAT_SECTOR;
            end
            pfcs_pkg::OP_BLOCK_ERASE: begin
              s.addr = c.addr & pfcs_pkg::BLOCK_MASK;    // R15
              s.data = pfcs_pkg::DAT_BLOCK;
            end
            default: s.data = pfcs_pkg::DAT_CHIP;        // R11
          endcase
        end
        default: ;                              // unlock first write
      endcase
    end
    return s;
  endfunction

  // index of the last write of a command
  function automatic logic [2:0] seq_last(input pfcs_pkg::pfcs_op_type op);
    case (op)
      pfcs_pkg::OP_PROGRAM:                         return 3'h3; // R7
      pfcs_pkg::OP_ID_ENTRY, pfcs_pkg::OP_ID_EXIT:  return 3'h2; // R6
      pfcs_pkg::OP_ID_RESET:                        return 3'h0;
      default:                                      return 3'h5; // R11
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // sequencer state
  // ----------------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,      // waiting for a command
    ST_WR_LOW = 6'h02,      // strobe low, data driven
    ST_WR_REC = 6'h04,      // strobe high between writes
    ST_RD     = 6'h08,      // read cycle in progress
    ST_GAP    = 6'h10,      // deselect gap, evaluate status
    ST_DONE   = 6'h20       // answer to the user
  } pfcs_state_type;

  pfcs_state_type              state_q;     // current state
  pfcs_state_type              state_d;     // next state
  pfcs_pkg::pfcs_cmd_type      cmd_q;       // command being run
  pfcs_pkg::pfcs_cmd_type      cmd_fix;     // command after remap
  logic [2:0]                  step_q;      // current bus cycle
  logic [pfcs_pkg::CNT_W-1:0]  cnt_q;       // cycles in this state
  logic                        polling_q;   // status polling active
  logic                        first_q;     // first status read
  logic                        prev_tgl_q;  // previous toggle bit
  logic [pfcs_pkg::DATA_W-1:0] rd_data_q;   // last byte read
  pfcs_pkg::pfcs_step_type     step_now;    // decoded bus cycle
  logic                        cnt_end;     // state time elapsed
  logic                        is_read;     // plain or id read
  logic                        toggling;    // bit 6 moved

  // small part has no block erase, so run chip erase instead
  assign cmd_fix.op   = (small_density &&
                         cmd.op == pfcs_pkg::OP_BLOCK_ERASE) ?
                        pfcs_pkg::OP_CHIP_ERASE : cmd.op;   // R16
  assign cmd_fix.addr = cmd.addr;
  assign cmd_fix.data = cmd.data;

  assign step_now = seq_step(cmd_q, step_q);
  assign is_read  = (cmd_fix.op == pfcs_pkg::OP_READ) ||
                    (cmd_fix.op == pfcs_pkg::OP_READ_HWID);
  assign toggling = rd_data_q[pfcs_pkg::TOGGLE_BIT] != prev_tgl_q; // R19
  assign cnt_end  =
    (state_q == ST_WR_LOW &&
     cnt_q == pfcs_pkg::CNT_W'(pfcs_pkg::WR_LOW_CYC - 1)) ||
    (state_q == ST_WR_REC &&
     cnt_q == pfcs_pkg::CNT_W'(pfcs_pkg::WR_REC_CYC - 1)) ||
    (state_q == ST_RD &&
     cnt_q == pfcs_pkg::CNT_W'(pfcs_pkg::RD_WAIT_CYC - 1));

  // next state; the device times its own work, the host only polls
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (cmd_valid) begin
          state_d = is_read ? ST_RD : ST_WR_LOW;
        end
      end
      ST_WR_LOW: begin
        if (cnt_end) begin
          state_d = ST_WR_REC;
        end
      end
      ST_WR_REC: begin
        if (cnt_end) begin
          if (step_q != seq_last(cmd_q.op)) begin
            state_d = ST_WR_LOW;
          end else if (seq_last(cmd_q.op) >= 3'h3) begin
            state_d = ST_RD;                    // R9
          end else begin
            state_d = ST_DONE;
          end
        end
      end
      ST_RD: begin
        if (cnt_end) begin
          state_d = ST_GAP;
        end
      end
      ST_GAP: begin
        // done once bit 6 holds still between two reads
        if (!polling_q || (!first_q && !toggling)) begin
          state_d = ST_DONE;                    // R19 R13
        end else begin
          state_d = ST_RD;                      // R12
        end
      end
      ST_DONE:  state_d = ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
  end

  // state, counters and captured data
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      state_q    <= ST_IDLE;
      cmd_q      <= '0;
      step_q     <= 3'h0;
      cnt_q      <= '0;
      polling_q  <= 1'b0;
      first_q    <= 1'b0;
      prev_tgl_q <= 1'b0;
      rd_data_q  <= 8'h00;
    end else begin
      state_q <= state_d;
      cnt_q   <= (state_d != state_q) ? '0 : cnt_q + 1'b1;
      if (state_q == ST_IDLE && cmd_valid) begin
        cmd_q     <= cmd_fix;
        step_q    <= 3'h0;
        polling_q <= 1'b0;
      end
      if (state_q == ST_WR_REC && cnt_end) begin
        step_q    <= step_q + 3'h1;
        polling_q <= 1'b1;                      // R9
        first_q   <= 1'b1;
      end
      if (state_q == ST_RD && cnt_end) begin
        rd_data_q <= din_sync_q;                // R17 R18
      end
      if (state_q == ST_GAP) begin
        first_q    <= 1'b0;
        prev_tgl_q <= rd_data_q[pfcs_pkg::TOGGLE_BIT];
      end
    end
  end

  // ----------------------------------------------------------------------
  // pin decode
  // ----------------------------------------------------------------------
  // strobes are decoded from the one-hot state flops alone; ce_n covers two of its states
  assign pins.we_n = !(state_q == ST_WR_LOW);                   // R21 R22
  assign pins.oe_n = !(state_q == ST_RD);                       // R1
  assign pins.ce_n = !(state_q == ST_WR_LOW || state_q == ST_RD); // R3
  // write address held through recovery so it never moves under a strobe
  assign pins.addr = (state_q == ST_WR_LOW || state_q == ST_WR_REC) ?
                     step_now.addr : cmd_q.addr;                // R2 R20
  assign data_bus_o  = step_now.data;                           // R2
  assign data_bus_oe = (state_q == ST_WR_LOW);                  // R4
  assign id_voltage_pin = (state_q == ST_RD) &&
                          (cmd_q.op == pfcs_pkg::OP_READ_HWID); // R5
  assign cmd_ready = (state_q == ST_IDLE);                      // R12
  assign rsp_valid = (state_q == ST_DONE);
  assign rsp_data  = rd_data_q;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n_sync);

  sequence s_strobe_fall;
    $fell(pins.we_n);
  endsequence
  sequence s_strobe_held;
    !pins.we_n [*4];
  endsequence

  AST_READ_STROBES: assert property ( // R1
    !pins.oe_n |-> !pins.ce_n && pins.we_n)
    else $error("read without select or with strobe low");
  AST_NO_DRIVE_ON_READ: assert property ( // R4
    !pins.oe_n |-> !data_bus_oe)
    else $error("data driven during enabled read");
  AST_WRITE_GATED: assert property ( // R21
    !pins.we_n |-> pins.oe_n && !pins.ce_n && data_bus_oe)
    else $error("write strobe without proper select");
  AST_STROBE_WIDTH: assert property ( // R22
    s_strobe_fall |-> s_strobe_held ##1 pins.we_n)
    else $error("write strobe not four cycles long");
  AST_WRITE_STABLE: assert property ( // R2
    !pins.we_n && $past(!pins.we_n) |->
      $stable(pins.addr) && $stable(data_bus_o))
    else $error("address or data moved under write strobe");
  AST_UNLOCK_FIRST: assert property ( // R23
    s_strobe_fall and (step_q == 3'h0 &&
    cmd_q.op != pfcs_pkg::OP_ID_RESET) |->
      pins.addr == pfcs_pkg::ADDR_UNLOCK1 &&
      data_bus_o == pfcs_pkg::DAT_UNLOCK1)
    else $error("command did not open with unlock write");
  AST_PROGRAM_TARGET: assert property ( // R8
    s_strobe_fall and (step_q == 3'h3 &&
    cmd_q.op == pfcs_pkg::OP_PROGRAM) |->
      pins.addr == cmd_q.addr && data_bus_o == cmd_q.data)
    else $error("fourth program write not the target");
  AST_ERASE_LAST: assert property ( // R24
    s_strobe_fall and (step_q == 3'h5 &&
    cmd_q.op == pfcs_pkg::OP_SECTOR_ERASE) |->
      data_bus_o == pfcs_pkg::DAT_SECTOR &&
      pins.addr[11:0] == 12'h000)
    else $error("sector erase final write wrong");
  AST_HV_ONLY_HWID: assert property ( // R5
    id_voltage_pin |-> !pins.oe_n &&
      cmd_q.op == pfcs_pkg::OP_READ_HWID)
    else $error("id voltage raised outside hardware id read");
  AST_BUSY_REFUSE: assert property ( // R12
    polling_q && state_q != ST_DONE && state_q != ST_IDLE |->
      !cmd_ready ##1 (pins.we_n || cmd_q == $past(cmd_q)))
    else $error("command accepted while operation runs");
  AST_IDLE_STANDBY: assert property ( // R3
    state_q == ST_IDLE |-> pins.ce_n && !data_bus_oe)
    else $error("device selected while idle");

endmodule

// File: src/pfcs_pkg.sv
// pfcs_pkg: constants, command codes and carrier types for the flash host
package pfcs_pkg;

  // ----------------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 19;              // address_bus, largest variant
  localparam int DATA_W = 8;               // data_bus width

  // ----------------------------------------------------------------------
  // command bus-cycle addresses and data
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_UNLOCK1 = 19'h0_0555;
  localparam logic [ADDR_W-1:0] ADDR_UNLOCK2 = 19'h0_02AA;
  localparam logic [DATA_W-1:0] DAT_UNLOCK1  = 8'hAA;
  localparam logic [DATA_W-1:0] DAT_UNLOCK2  = 8'h55;
  localparam logic [DATA_W-1:0] DAT_PROGRAM  = 8'hA0;
  localparam logic [DATA_W-1:0] DAT_ERASE    = 8'h80;
  localparam logic [DATA_W-1:0] DAT_CHIP     = 8'h10;
  localparam logic [DATA_W-1:0] DAT_SECTOR   = 8'h30;
  localparam logic [DATA_W-1:0] DAT_BLOCK    = 8'h50;
  localparam logic [DATA_W-1:0] DAT_ID_ENTRY = 8'h90;
  localparam logic [DATA_W-1:0] DAT_ID_EXIT  = 8'hF0;

  // sector is 4 kbyte, block is 64 kbyte: low offset bits cleared
  localparam logic [ADDR_W-1:0] SECTOR_MASK  = 19'h7_F000;
  localparam logic [ADDR_W-1:0] BLOCK_MASK   = 19'h7_0000;

  // status bit positions on a read
  localparam int POLL_BIT   = 7;           // poll_status_bit
  localparam int TOGGLE_BIT = 6;           // toggle_status_bit

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_NS        = 10;       // 100 MHz
  localparam int NOISE_NS      = 5;        // shortest strobe the part takes
  localparam int NOISE_CYC     = (NOISE_NS + CLK_NS - 1) / CLK_NS;
  localparam int WR_MARGIN_CYC = 3;        // extra width over the filter
  localparam int WR_LOW_CYC    = NOISE_CYC + WR_MARGIN_CYC;
  localparam int WR_REC_CYC    = 2;        // strobe high between writes
  localparam int RD_WAIT_CYC   = 6;        // access time plus sync depth
  localparam int CNT_W         = 4;

  // ----------------------------------------------------------------------
  // user commands
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_READ         = 4'h0,
    OP_READ_HWID    = 4'h1,
    OP_PROGRAM      = 4'h2,
    OP_CHIP_ERASE   = 4'h3,
    OP_SECTOR_ERASE = 4'h4,
    OP_BLOCK_ERASE  = 4'h5,
    OP_ID_ENTRY     = 4'h6,
    OP_ID_EXIT      = 4'h7,
    OP_ID_RESET     = 4'h8
  } pfcs_op_type;

  typedef struct packed {
    pfcs_op_type         op;               // what to do
    logic [ADDR_W-1:0]   addr;             // target address
    logic [DATA_W-1:0]   data;             // program data
  } pfcs_cmd_type;

  typedef struct packed {
    logic                ce_n;             // chip select, low active
    logic                oe_n;             // output enable, low active
    logic                we_n;             // write strobe, low active
    logic [ADDR_W-1:0]   addr;             // address_bus
  } pfcs_pins_type;

  typedef struct packed {
    logic [ADDR_W-1:0]   addr;             // bus cycle address
    logic [DATA_W-1:0]   data;             // bus cycle data
  } pfcs_step_type;

endpackage

// File: verif/parallel_flash_cmd_sequencer_tb.sv
// parallel_flash_cmd_sequencer_tb: scenario bench for the flash host
`timescale 1ns/1ns
module parallel_flash_cmd_sequencer_tb;
  logic                    clk = 1'b0;
  logic                    rst_n = 1'b0;
  logic                    small_density = 1'b0;
  logic                    cmd_valid = 1'b0;
  logic                    cmd_ready;
  pfcs_pkg::pfcs_cmd_type  cmd = '0;
  logic                    rsp_valid;
  logic [7:0]              rsp_data;
  pfcs_pkg::pfcs_pins_type pins;
  logic                    id_voltage_pin;
  logic [7:0]              data_bus_o, model_dq, flash_dq, q;
  logic                    data_bus_oe;
  int                      busy_ns = 300;
  int                      fail_count = 0;
  int                      comparisons = 0;
  int                      cycles = 0;
  int                      writes = 0;
  // ----------------------------------------------------------------------
  // wiring: host drives the data wire while its enable is up
  // ----------------------------------------------------------------------
  assign flash_dq = data_bus_oe ? data_bus_o : model_dq;
  pfcs_host i_pfcs_host (.clk(clk), .rst_n(rst_n),
    .small_density(small_density), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd(cmd), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .pins(pins), .id_voltage_pin(id_voltage_pin),
    .data_bus_o(data_bus_o), .data_bus_oe(data_bus_oe),
    .data_bus_i(flash_dq));
  pfcs_flash_model i_pfcs_flash_model (.pins(pins),
    .id_voltage_pin(id_voltage_pin), .dq_in(flash_dq), .busy_ns(busy_ns),
    .dq_out(model_dq));
  initial forever #5 clk = ~clk;
  // hang guard: the whole run needs under two thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end
  // the host must never fight the flash on the data wire
  always @(posedge clk) if (data_bus_oe === 1'b1 && pins.oe_n !== 1'b1)
    check8(8'h00, 8'h01, "data driven during read");
  always @(negedge pins.we_n) writes++;
  task automatic check8(input logic [7:0] got, exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // one command: hold valid until taken, wait bounded for the answer
  task automatic run(input pfcs_pkg::pfcs_op_type op, input logic [18:0] a,
                     input logic [7:0] d, input int nwr);
    int n;
    @(posedge clk);
    #1 cmd = '{op, a, d};
    cmd_valid = 1'b1;
    writes = 0;
    // ready is looked at between edges, where it has settled
    while (cmd_ready !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1 cmd_valid = 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (rsp_valid !== 1'b1 && n < 3000);
    check8(8'(rsp_valid), 8'h01, "answer in time");
    q = rsp_data;
    check8(8'(writes), 8'(nwr), "bus write count");
  endtask
  task automatic rd(input logic [18:0] a, input logic [7:0] exp);
    run(pfcs_pkg::OP_READ, a, 8'h00, 0);
    check8(q, exp, "read byte");
  endtask
  task automatic prg(input logic [18:0] a, input logic [7:0] d);
    run(pfcs_pkg::OP_PROGRAM, a, d, 4);
  endtask
  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic s_reset();
    check8({pins.ce_n, pins.oe_n, pins.we_n, data_bus_oe, id_voltage_pin,
            cmd_ready, rsp_valid, 1'b0}, 8'hE4, "idle pins");
    check8(rsp_data, 8'h00, "reset data");
  endtask
  task automatic s_program();
    prg(19'h1_2345, 8'h5A);
    check8(q, 8'h5A, "program status end");
    prg(19'h1_2345, 8'hF0);
    check8(q, 8'h50, "second program");
    rd(19'h1_2345, 8'h50);
    rd(19'h1_2346, 8'hFF);
  endtask
  task automatic s_sector();
    prg(19'h1_2FFF, 8'h00);
    prg(19'h1_3000, 8'h00);
    run(pfcs_pkg::OP_SECTOR_ERASE, 19'h1_2ABC, 8'h00, 6);
    check8(q, 8'hFF, "erase status end");
    rd(19'h1_2FFF, 8'hFF);
    rd(19'h1_2345, 8'hFF);
    rd(19'h1_3000, 8'h00);
  endtask
  task automatic s_block();
    prg(19'h2_0000, 8'h11);
    run(pfcs_pkg::OP_BLOCK_ERASE, 19'h2_4567, 8'h00, 6);
    rd(19'h2_0000, 8'hFF);
    rd(19'h1_3000, 8'h00);
    small_density = 1'b1;
    prg(19'h2_0000, 8'h22);
    run(pfcs_pkg::OP_BLOCK_ERASE, 19'h2_0000, 8'h00, 6);
    rd(19'h1_3000, 8'hFF);
    small_density = 1'b0;
  endtask
  task automatic s_chip();
    prg(19'h3_0000, 8'h33);
    run(pfcs_pkg::OP_CHIP_ERASE, 19'h0_0000, 8'h00, 6);
    prg(19'h3_0001, 8'h3C);
    rd(19'h3_0000, 8'hFF);
    rd(19'h3_0001, 8'h3C);
  endtask
  task automatic s_ident();
    run(pfcs_pkg::OP_ID_ENTRY, 19'h0_0000, 8'h00, 3);
    rd(19'h4_0000, 8'h01);
    rd(19'h7_0001, 8'h02);
    run(pfcs_pkg::OP_ID_RESET, 19'h5_5555, 8'h00, 1);
    rd(19'h3_0001, 8'h3C);
    run(pfcs_pkg::OP_ID_ENTRY, 19'h0_0000, 8'h00, 3);
    run(pfcs_pkg::OP_ID_EXIT, 19'h0_0000, 8'h00, 3);
    rd(19'h3_0001, 8'h3C);
    run(pfcs_pkg::OP_READ_HWID, 19'h6_0000, 8'h00, 0);
    check8(q, 8'h01, "hw id low");
    run(pfcs_pkg::OP_READ_HWID, 19'h6_0001, 8'h00, 0);
    check8(q, 8'h02, "hw id high");
    rd(19'h6_0001, 8'hFF);
  endtask
  task automatic s_slow();
    busy_ns = 5000;
    prg(19'h6_0000, 8'h81);
    check8(q, 8'h81, "slow program end");
    busy_ns = 300;
  endtask
  task automatic report_and_stop();
    if (fail_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    #1 s_reset();
    @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clk);
    s_program();
    s_sector();
    s_block();
    s_chip();
    s_ident();
    s_slow();
    report_and_stop();
  end
endmodule

// File: verif/pfcs_flash_model.sv
// pfcs_flash_model: behavioural byte-wide flash seen through the host pins
`timescale 1ns/1ns
module pfcs_flash_model #(
  parameter logic [7:0] MAN_CODE = 8'h01,  // arbitrary value
  parameter logic [7:0] DEV_CODE = 8'h02   // arbitrary value
) (
  input  wire pfcs_pkg::pfcs_pins_type pins,
  input  wire logic                    id_voltage_pin,
  input  wire logic [7:0]              dq_in,
  input  wire logic [31:0]             busy_ns,
  output      logic [7:0]              dq_out
);
  // ----------------------------------------------------------------------
  // array and sequencer state
  // ----------------------------------------------------------------------
  logic [7:0]  mem [int];                  // absent bytes read as erased
  logic [18:0] wa;                         // latched write address
  logic [7:0]  wd;                         // latched write data
  logic [7:0]  rv   = 8'h00;               // byte of the current read
  logic [7:0]  last = 8'h00;               // last programmed byte
  logic        busy = 1'b0;                // self-timed operation running
  logic        prog = 1'b0;                // running operation is a program
  logic        tog  = 1'b0;                // toggle_status_bit source
  logic        idm  = 1'b0;                // software id mode
  int          stp  = 0;                   // command sequence step
  realtime     t_fall;                     // start of the write gate
  event        go;                         // starts the internal timer
  wire wr_gate = !pins.ce_n && !pins.we_n && pins.oe_n;
  wire rd      = !pins.ce_n && !pins.oe_n && pins.we_n;
  // released bus shows the inverse, never a stale byte
  assign dq_out = rd ? rv : ~rv;
  function automatic logic [7:0] rd_mem(input int a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction
  // erase every written byte whose masked address matches
  task automatic wipe(input logic [18:0] a, input logic [18:0] m);
    foreach (mem[k]) if ((19'(k) & m) == (a & m)) mem[k] = 8'hFF;
    prog = 1'b0;
    busy = 1'b1;
    ->go;
  endtask
  // ----------------------------------------------------------------------
  // command decoder: any broken step drops back to idle, array untouched
  // ----------------------------------------------------------------------
  task automatic do_write(input logic [18:0] a, input logic [7:0] d);
    logic u1;
    u1 = (a == 19'h0_0555);
    if (busy) return;
    case (stp)
      0: begin
        if (d == 8'hF0) idm = 1'b0;
        stp = (u1 && d == 8'hAA) ? 1 : 0;
      end
      1, 5: stp = (a == 19'h0_02AA && d == 8'h55) ? stp + 1 : 0;
      2: begin
        stp = (u1 && d == 8'hA0) ? 3 : (u1 && d == 8'h80) ? 4 : 0;
        if (u1 && d == 8'h90) idm = 1'b1;
        if (u1 && d == 8'hF0) idm = 1'b0;
      end
      3: begin
        mem[a] = rd_mem(a) & d;
        last = d;
        prog = 1'b1;
        busy = 1'b1;
        stp = 0;
        ->go;
      end
      4: stp = (u1 && d == 8'hAA) ? 5 : 0;
      default: begin
        stp = 0;
        if (u1 && d == 8'h10) wipe(a, 19'h0_0000);
        else if (d == 8'h30) wipe(a, 19'h7_F000);
        else if (d == 8'h50) wipe(a, 19'h7_0000);
      end
    endcase
  endtask
  // address and data both taken at the later falling edge, none at the rising edge
  // pins are taken 1 ns into the gate: the host moves them on its edge
  always @(posedge wr_gate) begin
    t_fall = $realtime;
    #1;
    wa = pins.addr;
    wd = dq_in;
  end
  // a gate shorter than the filter never becomes a write
  always @(negedge wr_gate) begin
    if ($realtime - t_fall >= 5) do_write(wa, wd);
  end
  // internal timer; afterwards the part is idle again
  always @(go) begin
    #(busy_ns);
    busy = 1'b0;
  end
  // each read start while busy flips the toggle, whatever the address
  always @(posedge rd) begin
    #1;                                    // let address and id pin settle
    if (busy) begin
      tog = ~tog;
      rv = {prog ? ~last[7] : 1'b0, tog, 6'h15};
    end else if (idm || id_voltage_pin) begin
      rv = (pins.addr[1:0] == 2'h0) ? MAN_CODE : DEV_CODE;
    end else begin
      rv = rd_mem(pins.addr);
    end
  end
endmodule
